// File: hdl/sfdp_consts.vh
// Purpose: constants of the discovery table read responder
// Assumes: a single core clock that oversamples the serial clock
// Notes:   table bytes not listed here read as all ones
//
// Summary of operation
// - eight dummy clocks in single or dual mode, ten in quad
// - bytes stream from start address upward, wrapping at 2048 to zero
// - raising select during data output ends the read at once
// - read is always continuous; the burst wrap setting is ignored
// - bytes 00h-03h hold the signature 53h 46h 44h 50h
// - 04h minor 00h, 05h major 01h, 06h header count 00h, 07h FFh
// - parameter header: id 00h, rev 00h/01h, 09h dwords, pointer 30h, FFh
// - locations 10h through 2Fh read as all ones
// - byte 30h encodes erase size, granularity and write enable bits
// - byte 31h holds 4KB erase opcode 20h; byte 33h reads FFh
// - byte 32h flags 1-1-2 read, three address bytes, single rate
// - bytes 34h-37h give array size FFh FFh FFh 03h
// - byte 38h holds 1-4-4 dummy and mode counts, 39h opcode EBh
// - byte 3Ah holds 1-1-4 dummy and mode counts, 3Bh opcode 6Bh
// - byte 3Ch holds 1-1-2 dummy and mode counts, 3Dh opcode 3Bh
// - byte 3Eh holds 1-2-2 dummy and mode counts, 3Fh opcode BBh
// - byte 40h flags 2-2-2 and 4-4-4 read with reserved ones
// - 46h 2-2-2 counts, 47h opcode BBh; 41h-45h, 48h-49h all ones
// - byte 4Ah holds 4-4-4 counts, 4Bh opcode EBh
// - 4Ch-53h erase types 0Ch/20h, 10h/D8h, then four bytes of 00h
// - address bits are sampled on rising serial clock edges
`ifndef SFDP_CONSTS_VH
`define SFDP_CONSTS_VH

// protocol select codes
`define SFDP_PROTO_EXT   2'h0
`define SFDP_PROTO_DUAL  2'h1
`define SFDP_PROTO_QUAD  2'h2

// framing lengths in serial clocks, and the table address width in bits
`define SFDP_CMD_BITS    6'h08
`define SFDP_ADDR_BITS   6'h18
`define SFDP_DUMMY_SD    6'h08
`define SFDP_DUMMY_Q     6'h0a
`define SFDP_ADDR_W      11

// buffer shape
`define SFDP_FIFO_W      8
`define SFDP_FIFO_D      8

// table contents
`define SFDP_B_BLANK     8'hff
`define SFDP_B00         8'h53
`define SFDP_B01         8'h46
`define SFDP_B02         8'h44
`define SFDP_B03         8'h50
`define SFDP_B04         8'h00
`define SFDP_B05         8'h01
`define SFDP_B06         8'h00
`define SFDP_B08         8'h00
`define SFDP_B09         8'h00
`define SFDP_B0A         8'h01
`define SFDP_B0B         8'h09
`define SFDP_B0C         8'h30
`define SFDP_B0D         8'h00
`define SFDP_B0E         8'h00
`define SFDP_B30         8'he5
`define SFDP_B31         8'h20
`define SFDP_B32         8'hf1
`define SFDP_B37         8'h03
`define SFDP_B38         8'h29
`define SFDP_B39         8'heb
`define SFDP_B3A         8'h27
`define SFDP_B3B         8'h6b
`define SFDP_B3C         8'h08
`define SFDP_B3D         8'h3b
`define SFDP_B3E         8'h27
`define SFDP_B3F         8'hbb
`define SFDP_B40         8'hff
`define SFDP_B46         8'h27
`define SFDP_B47         8'hbb
`define SFDP_B4A         8'h29
`define SFDP_B4B         8'heb
`define SFDP_B4C         8'h0c
`define SFDP_B4D         8'h20
`define SFDP_B4E         8'h10
`define SFDP_B4F         8'hd8
`define SFDP_B_NONE      8'h00

`endif

// File: hdl/sfdp_resp.v
// Purpose: serve the discovery parameter table to an external serial host
// Assumes: clk at least eight times the serial clock; nrst synchronous
// Notes:   table bytes pass through a small fifo on their way to the pins
`timescale 1ns/1ps
`include "sfdp_consts.vh"

////////////////////////////////////////////////////////////////////////////
// small synchronous fifo with flush
////////////////////////////////////////////////////////////////////////////
module sfdp_fifo #(
  parameter WIDTH = `SFDP_FIFO_W,
  parameter DEPTH = `SFDP_FIFO_D,
  parameter AW    = 3
) (
  input  wire             clk,       // core clock
  input  wire             nrst,      // synchronous reset, active low
  input  wire             flush,     // drop all entries
  input  wire             in_valid,  // writer offers a word
  output wire             in_ready,  // space for a word
  input  wire [WIDTH-1:0] in_data,   // word written
  output wire             out_valid, // a word is waiting
  input  wire             out_ready, // reader takes the word
  output wire [WIDTH-1:0] out_data   // oldest word
);
  // storage, pointers and fill level
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            push;
  wire            pop;

  // handshakes on both sides
  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // storage write
  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers and fill level; flush beats any transfer
  // count separates full from empty when the pointers meet
  always @(posedge clk) begin
    if (!nrst || flush) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                   : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                   : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // sfdp_fifo

////////////////////////////////////////////////////////////////////////////
// discovery table read responder
////////////////////////////////////////////////////////////////////////////
module sfdp_resp #(
  parameter [7:0] READ_OPCODE = 8'h5a   // opcode that starts the read
) (
  input  wire       clk,         // core clock, 25 MHz
  input  wire       nrst,        // synchronous reset, active low
  input  wire       sel_n,       // chip select pin, active low
  input  wire       sclk,        // serial clock pin
  input  wire [3:0] dq_in,       // data pins, input side
  input  wire [1:0] proto,       // extended, dual or quad protocol
  output reg  [3:0] dq_out,      // data pins, output side
  output reg  [3:0] dq_oe,       // data pins, drive enables
  output reg        busy,        // a discovery read is in progress
  output reg        streaming    // data output phase reached
);
  // frame states
  localparam [2:0] ST_CMD   = 3'h0;
  localparam [2:0] ST_ADDR  = 3'h1;
  localparam [2:0] ST_DUMMY = 3'h2;
  localparam [2:0] ST_DATA  = 3'h3;
  localparam [2:0] ST_IGN   = 3'h4;

  // pin synchroniser stages
  reg                    sel_s1;
  reg                    sel_s2;
  reg                    sclk_s1;
  reg                    sclk_s2;
  reg                    sclk_s3;
  reg  [3:0]             dq_s1;
  reg  [3:0]             dq_s2;
  // frame state, shift registers and table fetch
  reg  [2:0]             state;
  reg  [5:0]             bit_cnt;
  reg  [22:0]            in_sr;
  reg  [`SFDP_ADDR_W-1:0] prod_ptr;
  reg                    prod_en;
  reg  [7:0]             obuf;
  reg  [3:0]             bits_left;
  // decoded strobes and fifo handshake
  wire                   rise;
  wire                   fall;
  wire [5:0]             dummy_need;
  wire [2:0]             step;
  wire                   fifo_ready;
  wire                   fifo_valid;
  wire [7:0]             fifo_data;
  // combinational lane selection
  reg                    fifo_pop;
  reg  [7:0]             src;
  reg  [3:0]             next_dq;
  reg  [3:0]             next_oe;

  ////////////////////////////////////////////////////////////////////////
  // table contents by location
  ////////////////////////////////////////////////////////////////////////
  function [7:0] table_byte;
    input [`SFDP_ADDR_W-1:0] a;
    begin
      case (a)
        11'h000: table_byte = `SFDP_B00;
        11'h001: table_byte = `SFDP_B01;
        11'h002: table_byte = `SFDP_B02;
        11'h003: table_byte = `SFDP_B03;
        11'h004: table_byte = `SFDP_B04;
        11'h005: table_byte = `SFDP_B05;
        11'h006: table_byte = `SFDP_B06;
        11'h008: table_byte = `SFDP_B08;
        11'h009: table_byte = `SFDP_B09;
        11'h00a: table_byte = `SFDP_B0A;
        11'h00b: table_byte = `SFDP_B0B;
        11'h00c: table_byte = `SFDP_B0C;
        11'h00d: table_byte = `SFDP_B0D;
        11'h00e: table_byte = `SFDP_B0E;
        11'h030: table_byte = `SFDP_B30;
        11'h031: table_byte = `SFDP_B31;
        11'h032: table_byte = `SFDP_B32;
        11'h037: table_byte = `SFDP_B37;
        11'h038: table_byte = `SFDP_B38;
        11'h039: table_byte = `SFDP_B39;
        11'h03a: table_byte = `SFDP_B3A;
        11'h03b: table_byte = `SFDP_B3B;
        11'h03c: table_byte = `SFDP_B3C;
        11'h03d: table_byte = `SFDP_B3D;
        11'h03e: table_byte = `SFDP_B3E;
        11'h03f: table_byte = `SFDP_B3F;
        11'h040: table_byte = `SFDP_B40;
        11'h046: table_byte = `SFDP_B46;
        11'h047: table_byte = `SFDP_B47;
        11'h04a: table_byte = `SFDP_B4A;
        11'h04b: table_byte = `SFDP_B4B;
        11'h04c: table_byte = `SFDP_B4C;
        11'h04d: table_byte = `SFDP_B4D;
        11'h04e: table_byte = `SFDP_B4E;
        11'h04f: table_byte = `SFDP_B4F;
        11'h050: table_byte = `SFDP_B_NONE;
        11'h051: table_byte = `SFDP_B_NONE;
        11'h052: table_byte = `SFDP_B_NONE;
        11'h053: table_byte = `SFDP_B_NONE;
        // unused, reserved and size locations that read as all ones
        11'h007: table_byte = `SFDP_B_BLANK;
        11'h00f: table_byte = `SFDP_B_BLANK;
        11'h033: table_byte = `SFDP_B_BLANK;
        11'h034: table_byte = `SFDP_B_BLANK;
        11'h035: table_byte = `SFDP_B_BLANK;
        11'h036: table_byte = `SFDP_B_BLANK;
        11'h041: table_byte = `SFDP_B_BLANK;
        11'h042: table_byte = `SFDP_B_BLANK;
        11'h043: table_byte = `SFDP_B_BLANK;
        11'h044: table_byte = `SFDP_B_BLANK;
        11'h045: table_byte = `SFDP_B_BLANK;
        11'h048: table_byte = `SFDP_B_BLANK;
        11'h049: table_byte = `SFDP_B_BLANK;
        // 10h-2Fh and everything above 53h
        default: table_byte = `SFDP_B_BLANK;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  ////////////////////////////////////////////////////////////////////////
  // two stages on every pin, a third on the clock for edge finding
  // data pins share the clock's delay, so bits line up with its edges
  always @(posedge clk) begin
    if (!nrst) begin
      sel_s1  <= 1'b1;
      sel_s2  <= 1'b1;
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_s3 <= 1'b0;
      dq_s1   <= 4'h0;
      dq_s2   <= 4'h0;
    end else begin
      sel_s1  <= sel_n;
      sel_s2  <= sel_s1;
      sclk_s1 <= sclk;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      dq_s1   <= dq_in;
      dq_s2   <= dq_s1;
    end
  end

  // serial clock edges, seen after synchronisation
  // edges show up two to three core clocks after the pin moves
  assign rise = sclk_s2 & ~sclk_s3;
  assign fall = ~sclk_s2 & sclk_s3;

  // dummy length depends on the protocol in use
  assign dummy_need = (proto == `SFDP_PROTO_QUAD) ? `SFDP_DUMMY_Q
                                                  : `SFDP_DUMMY_SD;

  // bits per serial clock in the data phase
  assign step = (proto == `SFDP_PROTO_QUAD) ? 3'h4 :
                (proto == `SFDP_PROTO_DUAL) ? 3'h2 : 3'h1;

  ////////////////////////////////////////////////////////////////////////
  // table fetch into the fifo
  ////////////////////////////////////////////////////////////////////////
  // the fetch runs up to eight bytes ahead of the shifter, so a
  // table look-up never sits in the serial clock's path
  sfdp_fifo #(
    .WIDTH     (`SFDP_FIFO_W),
    .DEPTH     (`SFDP_FIFO_D),
    .AW        (3)
  ) u_fifo (
    .clk       (clk),
    .nrst      (nrst),
    .flush     (sel_s2),
    .in_valid  (prod_en),
    .in_ready  (fifo_ready),
    .in_data   (table_byte(prod_ptr)),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // output lane selection
  ////////////////////////////////////////////////////////////////////////
  // pick the byte to shift and map its top bits onto the lanes
  // with sclk eight core clocks or longer the fifo never runs dry;
  // should it, blank bytes are shifted rather than stale data
  always @* begin
    fifo_pop = 1'b0;
    src      = obuf;
    if (state == ST_DATA && fall && bits_left == 4'h0) begin
      fifo_pop = fifo_valid;
      src      = fifo_valid ? fifo_data : `SFDP_B_BLANK;
    end
    case (proto)
      `SFDP_PROTO_QUAD: begin
        next_dq = src[7:4];
        next_oe = 4'hf;
      end
      `SFDP_PROTO_DUAL: begin
        next_dq = {2'h0, src[7:6]};
        next_oe = 4'h3;
      end
      default: begin
        next_dq = {2'h0, src[7], 1'b0};  // single line uses lane one
        next_oe = 4'h2;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // frame sequencer
  ////////////////////////////////////////////////////////////////////////
  // select high aborts whatever phase the frame is in
  // outputs change only on core clock edges, straight from flip-flops
  always @(posedge clk) begin
    if (!nrst) begin
      // lines released, nothing in flight
      state     <= ST_CMD;
      bit_cnt   <= 6'h00;
      in_sr     <= 23'h000000;
      prod_ptr  <= {`SFDP_ADDR_W{1'b0}};
      prod_en   <= 1'b0;
      obuf      <= 8'h00;
      bits_left <= 4'h0;
      dq_out    <= 4'h0;
      dq_oe     <= 4'h0;
      busy      <= 1'b0;
      streaming <= 1'b0;
    end else if (sel_s2) begin
      // the fifo is flushed by the same synchronised select
      state     <= ST_CMD;
      bit_cnt   <= 6'h00;
      prod_en   <= 1'b0;
      bits_left <= 4'h0;
      dq_oe     <= 4'h0;
      busy      <= 1'b0;
      streaming <= 1'b0;
    end else begin
      // fetch runs ahead while the fifo has room; 11-bit pointer wraps
      if (prod_en && fifo_ready) begin
        prod_ptr <= prod_ptr + 1'b1;
      end
      case (state)
        // opcode, one bit per serial rise on line zero
        ST_CMD: begin
          if (rise) begin
            in_sr   <= {in_sr[21:0], dq_s2[0]};
            bit_cnt <= bit_cnt + 1'b1;
            if (bit_cnt == `SFDP_CMD_BITS - 1'b1) begin
              bit_cnt <= 6'h00;
              if ({in_sr[6:0], dq_s2[0]} == READ_OPCODE) begin
                state <= ST_ADDR;
                busy  <= 1'b1;
              end else begin
                state <= ST_IGN;
              end
            end
          end
        end
        // address, low eleven bits kept as the start location
        ST_ADDR: begin
          if (rise) begin
            in_sr   <= {in_sr[21:0], dq_s2[0]};
            bit_cnt <= bit_cnt + 1'b1;
            if (bit_cnt == `SFDP_ADDR_BITS - 1'b1) begin
              bit_cnt  <= 6'h00;
              prod_ptr <= {in_sr[9:0], dq_s2[0]};
              prod_en  <= 1'b1;
              state    <= ST_DUMMY;
            end
          end
        end
        // dummy clocks, length set by the protocol in use
        ST_DUMMY: begin
          if (rise) begin
            bit_cnt <= bit_cnt + 1'b1;
            if (bit_cnt == dummy_need - 1'b1) begin
              bit_cnt   <= 6'h00;
              bits_left <= 4'h0;
              state     <= ST_DATA;
            end
          end
        end
        ST_DATA: begin
          // drive after each falling edge so the host samples on rise
          if (fall) begin
            dq_out    <= next_dq;
            dq_oe     <= next_oe;
            streaming <= 1'b1;
            obuf      <= src << step;
            // a new byte is loaded once the previous one is used up
            if (bits_left == 4'h0) begin
              bits_left <= 4'h8 - {1'b0, step};
            end else begin
              bits_left <= bits_left - {1'b0, step};
            end
          end
        end
        // foreign opcode: stay silent until select rises
        ST_IGN: begin
          bit_cnt <= 6'h00;              // other commands wait out the frame
        end
        // unused codes park until the frame ends
        default: begin
          state <= ST_IGN;
        end
      endcase
    end
  end
endmodule // sfdp_resp

// File: test/sfdp_resp_assertions.sv
// Purpose: port checker for the discovery table responder
// Assumes: serial clock period of eight core clocks
// Notes:   counts raw serial clock rises inside each frame
`timescale 1ns/1ps
module sfdp_chk (
  input wire       clk,       // core clock
  input wire       nrst,      // reset, active low
  input wire       sel_n,     // select pin
  input wire       sclk,      // serial clock pin
  input wire [3:0] dq_in,     // data pins in
  input wire [1:0] proto,     // protocol select
  input wire [3:0] dq_out,    // data pins out
  input wire [3:0] dq_oe,     // drive enables
  input wire       busy,      // read in progress
  input wire       streaming  // data phase
);
  reg        sclk_q; // serial clock one core clock ago
  reg [11:0] rises;  // serial rises within this frame

  ////////////////////////////////////////////////////////////////////////////
  // rise counter, cleared while select is high
  always @(posedge clk) begin
    sclk_q <= sclk;
    if (!nrst || sel_n)
      rises <= 12'h000;
    else if (sclk && !sclk_q)
      rises <= rises + 12'h001;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  ////////////////////////////////////////////////////////////////////////////
  AST_BUSY_AT_OPCODE: assert property ($rose(busy) |->
    rises == 12'h008)
    else $error("busy rose away from the eighth serial clock");
  AST_DUMMY_COUNT: assert property ($rose(streaming) |->
    rises == ((proto == 2'h2) ? 12'h02a : 12'h028))
    else $error("data phase began after a wrong dummy count");
  AST_STREAM_IN_READ: assert property (streaming |-> busy)
    else $error("streaming without a read in progress");
  AST_ENABLE_PATTERN: assert property (streaming && !sel_n |->
    dq_oe == ((proto == 2'h2) ? 4'hf : (proto == 2'h1) ? 4'h3 : 4'h2))
    else $error("wrong lanes driven for the protocol");
  AST_QUIET_WHEN_IDLE: assert property (!streaming |->
    dq_oe == 4'h0)
    else $error("lanes driven outside the data phase");
  AST_RELEASE_ON_SELECT: assert property (sel_n [*5] |->
    dq_oe == 4'h0 && !busy && !streaming)
    else $error("select high did not end the read");
  AST_BUSY_ENDS: assert property ($rose(sel_n) |-> ##[1:5] !busy)
    else $error("busy stayed after select rose");
  AST_HOLD_WHILE_HIGH: assert property (streaming &&
    $rose(sclk) |=> (sel_n || $stable(dq_out)) [*3])
    else $error("output changed while serial clock high");

  COV_EXT: cover property ($rose(streaming) && proto == 2'h0);
  COV_DUAL: cover property ($rose(streaming) && proto == 2'h1);
  COV_QUAD: cover property ($rose(streaming) && proto == 2'h2);
  COV_ABORT: cover property ($rose(sel_n) && streaming);
endmodule // sfdp_chk

bind sfdp_resp sfdp_chk u_chk (.clk(clk), .nrst(nrst), .sel_n(sel_n),
  .sclk(sclk), .dq_in(dq_in), .proto(proto), .dq_out(dq_out),
  .dq_oe(dq_oe), .busy(busy), .streaming(streaming));

// File: test/sfdp_host.sv
// Purpose: serial host model issuing discovery reads
// Assumes: serial clock period of eight core clocks
// Notes:   released lines show a pattern toggling every clock
`timescale 1ns/1ps
module sfdp_host (
  input  wire       clk,    // core clock
  input  wire [3:0] dq_out, // device data out
  input  wire [3:0] dq_oe,  // device drive enables
  output reg        sel_n,  // select, active low
  output reg        sclk,   // serial clock
  output wire [3:0] dq_in,  // resolved data pins
  output reg  [1:0] proto   // protocol select
);
  reg         hoe;  // host drives line zero
  reg         hbit; // host bit on line zero
  reg   [3:0] junk; // level of released lines
  logic [7:0] rx[$];  // bytes received
  logic [3:0] rxo[$]; // enables seen per byte

  ////////////////////////////////////////////////////////////////////////////
  // pin levels from every party's enable
  assign dq_in = (dq_oe & dq_out) |
                 (~dq_oe & {junk[3:1], hoe ? hbit : junk[0]});
  initial begin
    sel_n = 1'b1;
    sclk = 1'b0;
    hoe = 1'b0;
    hbit = 1'b0;
    junk = 4'h5;
    proto = 2'h0;
  end
  always @(posedge clk) junk <= ~junk;

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // one serial clock; bits move only while it is low
  task automatic pulse;
    tick(4);
    sclk = 1'b1;
    tick(4);
    sclk = 1'b0;
  endtask

  // opcode, address, dummies, nb bytes, cut extra clocks, release
  task automatic frame(input [7:0] op, input [23:0] ad, input [1:0] pr,
                       input int nb, input int cut);
    logic [31:0] sh;
    logic [7:0]  b;
    logic [3:0]  ln;
    logic [3:0]  o;
    int          w;
    w = (pr == 2'h2) ? 4 : (pr == 2'h1) ? 2 : 1;
    sh = {op, ad};
    rx.delete();
    rxo.delete();
    proto = pr;
    sel_n = 1'b0;
    for (int i = 0; i < ((pr == 2'h2) ? 42 : 40); i++) begin
      hoe = (i < 32);
      hbit = sh[31];
      sh = sh << 1;
      pulse();
    end
    for (int j = 0; j < nb; j++) begin
      b = 8'h00;
      for (int k = 0; k < 8 / w; k++) begin
        tick(4);
        ln = (w == 1) ? {3'h0, dq_in[1]} :
             (w == 2) ? {2'h0, dq_in[1:0]} : dq_in;
        b = (b << w) | {4'h0, ln};
        o = dq_oe;
        sclk = 1'b1;
        tick(4);
        sclk = 1'b0;
      end
      rx.push_back(b);
      rxo.push_back(o);
    end
    repeat (cut) pulse();
    tick(4);
    sel_n = 1'b1;
    tick(8);
  endtask
endmodule // sfdp_host

// File: test/test_sfdp_table_read_responder.sv
// Purpose: self-checking bench for the discovery table responder
// Assumes: default opcode 5ah; serial clock 320 ns
// Notes:   expected table held as a plain lookup
`timescale 1ns/1ps
module test_sfdp_table_read_responder;
  logic       clk = 1'b0;  // core clock
  logic       nrst = 1'b0; // reset, active low
  wire        sel_n;       // select
  wire        sclk;        // serial clock
  wire  [3:0] dq_in;       // data pins in
  wire  [3:0] dq_out;      // data pins out
  wire  [3:0] dq_oe;       // drive enables
  wire  [1:0] proto;       // protocol
  wire        busy;        // read in progress
  wire        streaming;   // data phase
  int         error_cnt = 0;
  int         checks = 0;

  always #20 clk = ~clk;

  sfdp_resp u_dut (.clk(clk), .nrst(nrst), .sel_n(sel_n), .sclk(sclk),
    .dq_in(dq_in), .proto(proto), .dq_out(dq_out), .dq_oe(dq_oe),
    .busy(busy), .streaming(streaming));
  sfdp_host u_host (.clk(clk), .dq_out(dq_out), .dq_oe(dq_oe),
    .sel_n(sel_n), .sclk(sclk), .dq_in(dq_in), .proto(proto));

  ////////////////////////////////////////////////////////////////////////////
  // expected table byte at a location
  function automatic logic [7:0] tbl(input int a);
    case (a)
      0: return 8'h53;
      1: return 8'h46;
      2: return 8'h44;
      3: return 8'h50;
      4, 6, 8, 9, 'h0d, 'h0e: return 8'h00;
      5, 'h0a: return 8'h01;
      'h0b: return 8'h09;
      'h0c: return 8'h30;
      'h30: return 8'he5;
      'h31, 'h4d: return 8'h20;
      'h32: return 8'hf1;
      'h37: return 8'h03;
      'h38, 'h4a: return 8'h29;
      'h39, 'h4b: return 8'heb;
      'h3a, 'h3e, 'h46: return 8'h27;
      'h3b: return 8'h6b;
      'h3c: return 8'h08;
      'h3d: return 8'h3b;
      'h3f, 'h47: return 8'hbb;
      'h4c: return 8'h0c;
      'h4e: return 8'h10;
      'h4f: return 8'hd8;
      'h50, 'h51, 'h52, 'h53: return 8'h00;
      default: return 8'hff;
    endcase
  endfunction

  task automatic chk(input string nm, input logic [7:0] got,
                     input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask

  // one read, then every enable, and for opcode 5ah every byte, against the model
  task automatic rd(input [7:0] op, input [23:0] ad, input [1:0] pr,
                    input int nb, input int cut);
    logic [7:0] eo;
    u_host.frame(op, ad, pr, nb, cut);
    eo = (op != 8'h5a) ? 8'h00 : (pr == 2'h2) ? 8'h0f :
         (pr == 2'h1) ? 8'h03 : 8'h02;
    for (int j = 0; j < nb; j++) begin
      if (op == 8'h5a)
        chk("table byte", u_host.rx[j],
            tbl((int'(ad[10:0]) + j) % 2048));
      chk("drive enables", {4'h0, u_host.rxo[j]}, eo);
    end
    chk("idle enables", {4'h0, dq_oe}, 8'h00);
    chk("idle busy", {7'h00, busy}, 8'h00);
  endtask

  task end_sim;
    if (error_cnt == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    void'($urandom(12));
    repeat (8) @(posedge clk);
    #1 nrst = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk("reset enables", {4'h0, dq_oe}, 8'h00);
    chk("reset state", {6'h00, busy, streaming}, 8'h00);
    rd(8'h5a, 24'h000000, 2'h0, 96, 0);
    rd(8'h5a ^ (8'($urandom % 255) + 8'h01), 24'h000000, 2'h0, 2, 0);
    rd(8'h5a, 24'h000000, 2'h0, 2, 3);
    rd(8'h5a, 24'h000008, 2'h2, 1, 1);
    for (int p = 0; p < 3; p++)
      rd(8'h5a, {13'($urandom), 11'h7fc + 11'(p)}, 2'(p), 8, 0);
    repeat (3) rd(8'h5a, 24'($urandom), 2'($urandom % 3), 4, 0);
    end_sim();
  end

  // watchdog well beyond the expected run length
  initial begin
    #2000000;
    error_cnt++;
    end_sim();
  end
endmodule // test_sfdp_table_read_responder
